// [inc/expander_pkg.sv]
// constants, types and register map for the serial i/o expander port
// How it works
// - two-wire: four fixed plus three pin bits
// - four-wire: seven fixed address bits
// - eight pins, each input or output
// - drivers only pull low or release
// - per-pin pull-up in either direction
// - port value read returns pin levels
// - latch read returns stored latch bits
// - port value write lands in latch
// - output pins follow their latch bit
// - input pins leave driver off
// - eleven registers 00..0A, zero reset except direction
// - direction set means input, resets ones
// - inversion bit flips reported pin level
// - enable bit gates change events per pin
// - select 0 compares previous, 1 default
// - level opposite default bit raises event
// - clear-select picks capture or port read
// - pointer wraps to zero after last
package expander_pkg;

    // port and register geometry
    localparam int PORT_W = 8;
    localparam int REG_AW = 4;
    localparam int NUM_REGS = 11;

    // register offsets
    localparam logic [3:0] OFS_PIN_DIRECTION         = 4'h0;
    localparam logic [3:0] OFS_INPUT_INVERSION       = 4'h1;
    localparam logic [3:0] OFS_CHANGE_IRQ_ENABLE     = 4'h2;
    localparam logic [3:0] OFS_COMPARE_DEFAULT       = 4'h3;
    localparam logic [3:0] OFS_CHANGE_COMPARE_SELECT = 4'h4;
    localparam logic [3:0] OFS_DEVICE_CONFIG         = 4'h5;
    localparam logic [3:0] OFS_PULLUP_ENABLE         = 4'h6;
    localparam logic [3:0] OFS_IRQ_FLAGS             = 4'h7;
    localparam logic [3:0] OFS_IRQ_CAPTURE           = 4'h8;
    localparam logic [3:0] OFS_PORT_VALUE            = 4'h9;
    localparam logic [3:0] OFS_OUTPUT_LATCH          = 4'hA;
    localparam logic [3:0] LAST_REG                  = 4'hA;

    // values after reset
    localparam logic [7:0] RST_PIN_DIRECTION = 8'hFF;
    localparam logic [7:0] RST_ZERO          = 8'h00;

    // device configuration fields
    localparam int CFG_PTR_HOLD_BIT   = 5;
    localparam int CFG_OPEN_DRAIN_BIT = 2;
    localparam int CFG_IRQ_POL_BIT    = 1;
    localparam int CFG_CLEAR_SEL_BIT  = 0;
    localparam logic [7:0] CFG_WRITE_MASK = 8'h27;

    // slave address parts (arbitrary values)
    localparam logic [3:0] TWO_WIRE_FIXED_HI = 4'h4;
    localparam logic [6:0] FOUR_WIRE_FIXED   = 7'h20;

    // serial framing
    localparam logic [2:0] LAST_BIT         = 3'h7;
    localparam logic [1:0] ADDR_LATCH_DELAY = 2'h2;

    // phase of a serial frame
    typedef enum logic [1:0] {
        PH_OPCODE = 2'b00,
        PH_ADDR   = 2'b01,
        PH_DATA   = 2'b10,
        PH_IGNORE = 2'b11
    } frame_phase_t;

endpackage

// [verilog/sync2.sv]
// two flip-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;   // metastability catcher, read only below

    // two stages, second one is the only reader of the first
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

// [verilog/serial_io_expander_port.sv]
// eight-pin open-drain expander port behind a serial register bank
`timescale 1ns/1ps
module serial_io_expander_port #(
    parameter bit TWO_WIRE_ADDR = 1'b1  // 1: pin-selected address, 0: all fixed
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic [2:0] addr_pin,
    input  wire logic       ser_cs_b,
    input  wire logic       ser_sck,
    input  wire logic       ser_sdi,
    output logic            ser_sdo,
    output logic            ser_sdo_oe,
    input  wire logic [7:0] gpio_in,
    output logic      [7:0] gpio_out,
    output logic      [7:0] gpio_oe,
    output logic      [7:0] gpio_pullup,
    output logic            irq_out,
    output logic            irq_oe
);

    // nothing below reads a raw pin: all are asynchronous to clk_sys
    // price is about three clocks of lag on the serial link
    // synchronised copies of every outside input
    logic [2:0]  addr_s;        // address code from the decoder
    logic        cs_s;          // frame select, low active
    logic        sck_s;         // serial clock level
    logic        sdi_s;         // serial data in
    logic [7:0]  pin_s;         // pin levels
    logic [13:0] sync_q;        // packed synchroniser output

    // all pins and the serial lines cross on one synchroniser
    sync2 #(
        .WIDTH (14)
    ) u_sync (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .async_in ({addr_pin, ser_cs_b, ser_sck, ser_sdi, gpio_in}),
        .sync_out (sync_q)
    );

    assign addr_s = sync_q[13:11];
    assign cs_s   = sync_q[10];
    assign sck_s  = sync_q[9];
    assign sdi_s  = sync_q[8];
    assign pin_s  = sync_q[7:0];

    // register bank storage
    logic [7:0] pin_direction;          // 1 = input
    logic [7:0] input_inversion;        // 1 = report inverted level
    logic [7:0] change_irq_enable;      // per-pin event enable
    logic [7:0] compare_default;        // reference level
    logic [7:0] change_compare_select;  // 1 = against reference
    logic [7:0] device_config;          // sequencing and int pin setup
    logic [7:0] pullup_enable;          // per-pin pull-up
    logic [7:0] irq_flags;              // pins that caused the event
    logic [7:0] irq_capture;            // port value at event time
    logic [7:0] output_latch;           // stored output levels

    // hardware address capture
    logic [2:0] hw_addr;        // latched address code
    logic [1:0] addr_wait;      // waits out the synchroniser
    logic       addr_taken;     // address held until next reset

    // serial frame state
    expander_pkg::frame_phase_t phase;      // where we are in the frame
    expander_pkg::frame_phase_t next_phase; // phase after the current byte
    logic [2:0]                 bit_cnt;    // bit within current byte
    logic [6:0]                 rx;         // shift register, low seven bits
    logic                       is_read;    // frame direction from opcode
    logic [3:0]                 ptr;        // register pointer
    logic [7:0]                 tx;         // outgoing byte
    logic [3:0]                 tx_ptr;     // register the outgoing byte came from
    logic                       sck_prev;   // last sampled clock level

    // hold the address code once the synchroniser has settled
    // taken once after reset and kept: later pin moves are ignored
    // so the slave address cannot shift in the middle of a frame
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            hw_addr    <= 3'h0;
            addr_wait  <= 2'h0;
            addr_taken <= 1'b0;
        end else if (!addr_taken) begin
            if (addr_wait == expander_pkg::ADDR_LATCH_DELAY) begin
                hw_addr    <= addr_s;
                addr_taken <= 1'b1;
            end else begin
                addr_wait <= addr_wait + 2'h1;
            end
        end
    end

    // own slave address for the chosen bus variant
    wire [6:0] own_addr = TWO_WIRE_ADDR ?
        {expander_pkg::TWO_WIRE_FIXED_HI, hw_addr} :
        expander_pkg::FOUR_WIRE_FIXED;

    // clock edges found on the sampled serial clock
    // edges only count while selected; sck_prev idles low like
    // the mode 0,0 clock, so no false rise follows reset
    wire       sck_rise  = sck_s & ~sck_prev & ~cs_s;
    wire       sck_fall  = ~sck_s & sck_prev & ~cs_s;
    wire [7:0] rx_byte   = {rx, sdi_s};
    wire       byte_done = sck_rise & (bit_cnt == expander_pkg::LAST_BIT);
    wire       op_match  = (rx_byte[7:1] == own_addr);
    wire       in_data   = (phase == expander_pkg::PH_DATA);

    // pointer after a data byte, optionally frozen, wrapping at the top
    // compare is >= so an address byte past the top still wraps to zero
    wire       seq_hold = device_config[expander_pkg::CFG_PTR_HOLD_BIT];
    wire [3:0] ptr_next = seq_hold ? ptr :
        ((ptr >= expander_pkg::LAST_REG) ? 4'h0 : ptr + 4'h1);

    // phase sequencing of a frame
    always_comb begin
        case (phase)
            expander_pkg::PH_OPCODE: begin
                next_phase = op_match ? expander_pkg::PH_ADDR : expander_pkg::PH_IGNORE;
            end
            expander_pkg::PH_ADDR:   next_phase = expander_pkg::PH_DATA;
            expander_pkg::PH_DATA:   next_phase = expander_pkg::PH_DATA;
            expander_pkg::PH_IGNORE: next_phase = expander_pkg::PH_IGNORE;
            default:                 next_phase = expander_pkg::PH_IGNORE;
        endcase
    end

    // frame counters, reset whenever select is high
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sck_prev <= 1'b0;
            phase    <= expander_pkg::PH_OPCODE;
            bit_cnt  <= 3'h0;
            rx       <= 7'h00;
        end else begin
            sck_prev <= sck_s;
            if (cs_s) begin
                phase   <= expander_pkg::PH_OPCODE;
                bit_cnt <= 3'h0;
            end else if (sck_rise) begin
                rx      <= rx_byte[6:0];
                bit_cnt <= bit_cnt + 3'h1;
                if (byte_done) begin
                    phase <= next_phase;
                end
            end
        end
    end

    // read/write bit ends the opcode byte; address byte sets the pointer
    wire op_done   = byte_done & (phase == expander_pkg::PH_OPCODE) & op_match;
    wire addr_done = byte_done & (phase == expander_pkg::PH_ADDR);
    wire data_done = byte_done & in_data;

    // direction flag and register pointer
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            is_read <= 1'b0;
            ptr     <= 4'h0;
        end else begin
            if (op_done) begin
                is_read <= rx_byte[0];
            end
            if (addr_done) begin
                ptr <= rx_byte[3:0];
            end else if (data_done) begin
                ptr <= ptr_next;
            end
        end
    end

    // reported port value: synchronised pins, optionally inverted
    wire [7:0] port_value = pin_s ^ input_inversion;

    // read view of every register, unmapped reads as zero
    // offsets 0B..0F: zero on read, dropped by the write decode
    logic [7:0] reg_view [0:15];
    assign reg_view[0]  = pin_direction;
    assign reg_view[1]  = input_inversion;
    assign reg_view[2]  = change_irq_enable;
    assign reg_view[3]  = compare_default;
    assign reg_view[4]  = change_compare_select;
    assign reg_view[5]  = device_config;
    assign reg_view[6]  = pullup_enable;
    assign reg_view[7]  = irq_flags;
    assign reg_view[8]  = irq_capture;
    assign reg_view[9]  = port_value;
    assign reg_view[10] = output_latch;
    assign reg_view[11] = 8'h00;
    assign reg_view[12] = 8'h00;
    assign reg_view[13] = 8'h00;
    assign reg_view[14] = 8'h00;
    assign reg_view[15] = 8'h00;

    // next byte to send: fetched at the end of address or data byte
    wire       load_tx  = is_read & (addr_done | data_done);
    wire [3:0] read_ptr = addr_done ? rx_byte[3:0] : ptr_next;

    // outgoing shift register, msb first, changes on falling edges
    // fetched one byte ahead so bit 7 stands before the first rise
    // the fall ending an address byte sees bit_cnt zero: no shift
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            tx     <= 8'h00;
            tx_ptr <= 4'h0;
        end else if (load_tx) begin
            tx     <= reg_view[read_ptr];
            tx_ptr <= read_ptr;
        end else if (sck_fall && in_data && bit_cnt != 3'h0) begin
            tx <= {tx[6:0], 1'b0};
        end
    end

    // data line driven only while this device is answering
    assign ser_sdo    = tx[7];
    assign ser_sdo_oe = ~cs_s & is_read & in_data;

    // a read counts once its first bit is taken, so prefetch has no effect
    wire read_taken = sck_rise & in_data & is_read & (bit_cnt == 3'h0);

    // write decode, pointer selects the target
    wire       wr_event = data_done & ~is_read;
    wire [7:0] wr_data  = rx_byte;
    wire wr_dir   = wr_event & (ptr == expander_pkg::OFS_PIN_DIRECTION);
    wire wr_inv   = wr_event & (ptr == expander_pkg::OFS_INPUT_INVERSION);
    wire wr_en    = wr_event & (ptr == expander_pkg::OFS_CHANGE_IRQ_ENABLE);
    wire wr_def   = wr_event & (ptr == expander_pkg::OFS_COMPARE_DEFAULT);
    wire wr_sel   = wr_event & (ptr == expander_pkg::OFS_CHANGE_COMPARE_SELECT);
    wire wr_cfg   = wr_event & (ptr == expander_pkg::OFS_DEVICE_CONFIG);
    wire wr_pu    = wr_event & (ptr == expander_pkg::OFS_PULLUP_ENABLE);
    wire wr_latch = wr_event & ((ptr == expander_pkg::OFS_PORT_VALUE) |
                                (ptr == expander_pkg::OFS_OUTPUT_LATCH));

    // writable registers; flag and capture registers ignore writes
    // pin levels are never stored, only sampled; port value writes
    // land in the latch instead
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pin_direction         <= expander_pkg::RST_PIN_DIRECTION;
            input_inversion       <= expander_pkg::RST_ZERO;
            change_irq_enable     <= expander_pkg::RST_ZERO;
            compare_default       <= expander_pkg::RST_ZERO;
            change_compare_select <= expander_pkg::RST_ZERO;
            device_config         <= expander_pkg::RST_ZERO;
            pullup_enable         <= expander_pkg::RST_ZERO;
            output_latch          <= expander_pkg::RST_ZERO;
        end else begin
            if (wr_dir)   pin_direction         <= wr_data;
            if (wr_inv)   input_inversion       <= wr_data;
            if (wr_en)    change_irq_enable     <= wr_data;
            if (wr_def)   compare_default       <= wr_data;
            if (wr_sel)   change_compare_select <= wr_data;
            if (wr_cfg)   device_config         <= wr_data & expander_pkg::CFG_WRITE_MASK;
            if (wr_pu)    pullup_enable         <= wr_data;
            if (wr_latch) output_latch          <= wr_data;
        end
    end

    // previous pin levels for change detection
    logic [7:0] pin_prev;
    logic [7:0] change_cond;    // per-pin event condition
    logic [7:0] next_oe;        // per-pin driver enable

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pin_prev <= 8'h00;
        end else begin
            pin_prev <= pin_s;
        end
    end

    // per-pin driver and change condition
    // an output pin never raises an event: direction gates it too
    genvar gi;
    generate
        for (gi = 0; gi < expander_pkg::PORT_W; gi++) begin : g_pin
            // outputs sink when the latch is low, inputs never drive
            assign next_oe[gi] = ~pin_direction[gi] & ~output_latch[gi];
            // compare against reference or against the last level
            assign change_cond[gi] = change_irq_enable[gi] & pin_direction[gi] &
                (change_compare_select[gi] ?
                    (pin_s[gi] != compare_default[gi]) :
                    (pin_s[gi] != pin_prev[gi]));
        end
    endgenerate

    // open-drain pads: value is always low, enable decides
    assign gpio_out    = 8'h00;
    assign gpio_pullup = pullup_enable;

    // clearing source chosen by the configuration
    wire irq_active = |irq_flags;
    wire clear_by_cap = device_config[expander_pkg::CFG_CLEAR_SEL_BIT];
    wire clear_hit = read_taken & (clear_by_cap ?
        (tx_ptr == expander_pkg::OFS_IRQ_CAPTURE) :
        (tx_ptr == expander_pkg::OFS_PORT_VALUE));

    // flags and capture: set wins, clear only with condition gone
    // a pending event blocks new ones, so the capture keeps the port
    // value of the first cause; a clear against an active condition
    // is refused and the flag stays
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            irq_flags   <= expander_pkg::RST_ZERO;
            irq_capture <= expander_pkg::RST_ZERO;
        end else if (!irq_active && (|change_cond)) begin
            irq_flags   <= change_cond;
            irq_capture <= port_value;
        end else if (clear_hit && !(|change_cond)) begin
            irq_flags <= expander_pkg::RST_ZERO;
        end
    end

    // registered pad enables and interrupt pin
    // after reset the interrupt pin idles inactive: push-pull, low active
    wire odr_mode = device_config[expander_pkg::CFG_OPEN_DRAIN_BIT];
    wire int_pol  = device_config[expander_pkg::CFG_IRQ_POL_BIT];

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            gpio_oe <= 8'h00;
            irq_out <= 1'b1;
            irq_oe  <= 1'b1;
        end else begin
            gpio_oe <= next_oe;
            if (odr_mode) begin
                // open drain: sink while active, else released
                irq_out <= 1'b0;
                irq_oe  <= irq_active;
            end else begin
                // push-pull with chosen polarity
                irq_out <= irq_active ? int_pol : ~int_pol;
                irq_oe  <= 1'b1;
            end
        end
    end

endmodule

// [tb/serial_io_expander_port_chk.sv]
// port-level assertions for the expander port, bound to its top
`timescale 1ns/1ps
module serial_io_expander_port_chk (
    input wire logic       clk_sys,
    input wire logic       rst_b,
    input wire logic [2:0] addr_pin,
    input wire logic       ser_cs_b,
    input wire logic       ser_sck,
    input wire logic       ser_sdi,
    input wire logic       ser_sdo,
    input wire logic       ser_sdo_oe,
    input wire logic [7:0] gpio_in,
    input wire logic [7:0] gpio_out,
    input wire logic [7:0] gpio_oe,
    input wire logic [7:0] gpio_pullup,
    input wire logic       irq_out,
    input wire logic       irq_oe
);
    // one clock domain, reset disables everything
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // pins are only ever pulled low
    a_drive_low_only: assert property (gpio_out == 8'h00)
        else $error("pin output driven high");
    // reset leaves every pin released, no pull-up, link quiet
    a_reset_port_idle: assert property ($rose(rst_b) |->
        gpio_oe == 8'h00 && gpio_pullup == 8'h00 && !ser_sdo_oe)
        else $error("port not idle after reset");
    // interrupt pin idles inactive push-pull
    a_irq_reset_idle: assert property ($rose(rst_b) |-> irq_out && irq_oe)
        else $error("interrupt pin not idle after reset");
    // pull-ups only move through a register write
    a_pullup_by_frame: assert property ($changed(gpio_pullup) |-> !$past(ser_cs_b))
        else $error("pull-up changed outside a frame");
    // drivers only move through a latch or direction write
    a_driver_by_frame: assert property ($changed(gpio_oe) |-> !$past(ser_cs_b, 2))
        else $error("driver changed outside a frame");
    // answer only while selected
    a_sdo_rise_selected: assert property ($rose(ser_sdo_oe) |-> !ser_cs_b)
        else $error("data out enabled while deselected");
    // data line released soon after deselect
    a_sdo_released: assert property (ser_cs_b [*4] |=> !ser_sdo_oe)
        else $error("data out still enabled after deselect");
    // no pin activity and no frame: interrupt pin holds
    a_irq_quiet: assert property (($stable(gpio_in) && ser_cs_b) [*6] |=>
        $stable(irq_out) && $stable(irq_oe))
        else $error("interrupt pin moved without cause");
endmodule

bind serial_io_expander_port serial_io_expander_port_chk i_chk (
    .clk_sys(clk_sys), .rst_b(rst_b), .addr_pin(addr_pin), .ser_cs_b(ser_cs_b),
    .ser_sck(ser_sck), .ser_sdi(ser_sdi), .ser_sdo(ser_sdo), .ser_sdo_oe(ser_sdo_oe),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .gpio_pullup(gpio_pullup), .irq_out(irq_out), .irq_oe(irq_oe)
);

// [tb/spi_host_model.sv]
// host bus master model: frames on the serial link, own free phase
`timescale 1ns/1ps
module spi_host_model (
    output logic      ser_cs_b,
    output logic      ser_sck,
    output logic      ser_sdi,
    input  wire logic ser_sdo,
    input  wire logic ser_sdo_oe
);
    // released line shows the inverse of the last driven level
    wire  sdo_line = ser_sdo_oe ? ser_sdo : ~ser_sdo;
    logic oe_seen; // device answered during this frame

    // idle: deselected, clock low and still
    initial begin
        ser_cs_b = 1'b1;
        ser_sck = 1'b0;
        ser_sdi = 1'b0;
        oe_seen = 1'b0;
    end
    always @(posedge ser_sdo_oe) oe_seen = 1'b1;

    // one byte msb first: data set with clock low, taken on the rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            ser_sdi = tx[i];
            #100;
            ser_sck = 1'b1;
            rx[i] = sdo_line;
            #100;
            ser_sck = 1'b0;
        end
    endtask

    // whole frame: opcode, register address, then n data bytes
    task automatic frame(input logic [7:0] op, input logic [7:0] adr, input int n,
                         input logic [7:0] wd [16], output logic [7:0] rd [16]);
        logic [7:0] junk;
        oe_seen = 1'b0;
        #37;
        ser_cs_b = 1'b0;
        #100;
        xfer(op, junk);
        xfer(adr, junk);
        for (int k = 0; k < n; k++) xfer(wd[k], rd[k]);
        #100;
        ser_cs_b = 1'b1;
        ser_sdi = ~ser_sdi;
        #150;
    endtask
endmodule

// [tb/serial_io_expander_port_tb_top.sv]
// self-checking bench for the expander port against a register model
`timescale 1ns/1ps
module serial_io_expander_port_tb_top;
    logic       clk_sys, rst_b;          // clock and reset
    logic [2:0] addr_pin;                // hardware address code
    logic [7:0] ext;                     // level the outside offers each pin
    logic       ser_cs_b, ser_sck, ser_sdi, ser_sdo, ser_sdo_oe;
    logic [7:0] gpio_out, gpio_oe, gpio_pullup;
    logic       irq_out, irq_oe;
    wire  [7:0] pin_level = ext & ~gpio_oe; // open-drain wired pins
    wire  [6:0] own = {expander_pkg::TWO_WIRE_FIXED_HI, addr_pin};
    int         mismatches = 0;
    int         n_compared = 0;
    int         cycles = 0;
    int         m [11];                  // register model
    logic [7:0] wd [16];                 // bytes sent
    logic [7:0] rd [16];                 // bytes received

    serial_io_expander_port i_serial_io_expander_port (
        .clk_sys(clk_sys), .rst_b(rst_b), .addr_pin(addr_pin), .ser_cs_b(ser_cs_b),
        .ser_sck(ser_sck), .ser_sdi(ser_sdi), .ser_sdo(ser_sdo), .ser_sdo_oe(ser_sdo_oe),
        .gpio_in(pin_level), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .gpio_pullup(gpio_pullup), .irq_out(irq_out), .irq_oe(irq_oe));
    spi_host_model host (.ser_cs_b(ser_cs_b), .ser_sck(ser_sck), .ser_sdi(ser_sdi),
        .ser_sdo(ser_sdo), .ser_sdo_oe(ser_sdo_oe));

    // free-running system clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // hang guard
    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 40000) begin
            mismatches = mismatches + 1;
            end_of_test();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // model: pins pulled low where output with latch bit clear
    function automatic logic [7:0] exp_oe();
        return ~m[0][7:0] & ~m[10][7:0];
    endfunction
    // model: value read back at a register address
    function automatic logic [7:0] exp_rd(input int a);
        if (a == 9) return (ext & ~exp_oe()) ^ m[1][7:0];
        return m[a][7:0];
    endfunction
    // model: effect of a write
    task automatic mwrite(input int a, input logic [7:0] v);
        if (a == 5) m[5] = v & expander_pkg::CFG_WRITE_MASK;
        else if (a == 9) m[10] = v;
        else if (a != 7 && a != 8) m[a] = v;
    endtask
    task automatic wr(input int a, input int n);
        host.frame({own, 1'b0}, 8'(a), n, wd, rd);
        for (int k = 0; k < n; k++) mwrite((a + k) % 11, wd[k]);
    endtask
    task automatic rdchk(input int a, input int n);
        host.frame({own, 1'b1}, 8'(a), n, wd, rd);
        for (int k = 0; k < n; k++) check(rd[k], exp_rd((a + k) % 11));
    endtask
    task automatic pins_chk();
        repeat (4) @(posedge clk_sys);
        check(gpio_oe, exp_oe());
        check(gpio_pullup, m[6][7:0]);
    endtask
    task automatic irq_chk(input logic v);
        repeat (20) @(posedge clk_sys);
        check({irq_oe, irq_out}, {1'b1, v});
    endtask

    initial begin
        rst_b = 1'b0;
        addr_pin = 3'h0;
        ext = 8'h00;
        void'($urandom(32'hB4FBFC4B));
        for (int k = 0; k < 11; k++) m[k] = 0;
        m[0] = 8'hFF;
        @(posedge clk_sys);
        addr_pin <= 3'($urandom);
        ext <= 8'($urandom);
        repeat (7) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk_sys);
        // reset values, all inputs, pointer wraps past the last register
        pins_chk();
        rdchk(0, 13);
        // random configuration, readback of every register
        for (int r = 0; r < 3; r++) begin
            @(posedge clk_sys) ext <= 8'($urandom);
            for (int k = 0; k < 11; k++) wd[k] = 8'($urandom);
            wd[2] = 8'h00;
            wd[5] = 8'h00;
            wr(0, 11);
            pins_chk();
            rdchk(0, 11);
            wd[0] = 8'($urandom);
            wr(9, 1);
            rdchk(9, 3);
            pins_chk();
        end
        // opcode off by one pin bit: refused both ways
        wd[0] = ~m[10][7:0];
        host.frame({own ^ 7'h01, 1'b0}, 8'h0A, 1, wd, rd);
        host.frame({own ^ 7'h01, 1'b1}, 8'h0A, 1, wd, rd);
        check(host.oe_seen, 1'b0);
        rdchk(10, 1);
        check(host.oe_seen, 1'b1);
        // change interrupt on pin 0, compare with previous level
        @(posedge clk_sys) ext <= 8'($urandom) & 8'hFE;
        for (int k = 0; k < 6; k++) wd[k] = 8'h00;
        wd[0] = 8'hFF;
        wd[2] = 8'h01;
        wr(0, 6);
        irq_chk(1'b1);
        @(posedge clk_sys) ext[1] <= ~ext[1];
        irq_chk(1'b1);
        @(posedge clk_sys) ext[0] <= 1'b1;
        irq_chk(1'b0);
        m[8] = ext;
        rdchk(8, 1);
        irq_chk(1'b0);
        rdchk(9, 1);
        irq_chk(1'b1);
        // compare with default bit, cleared by capture read
        wd[0] = 8'h00;
        wd[1] = 8'h01;
        wd[2] = 8'h01;
        wr(3, 3);
        irq_chk(1'b0);
        rdchk(9, 1);
        irq_chk(1'b0);
        @(posedge clk_sys) ext[0] <= 1'b0;
        irq_chk(1'b0);
        rdchk(8, 1);
        irq_chk(1'b1);
        // pointer held, active-high idle, then open-drain idle
        wd[0] = 8'h23;
        wr(5, 1);
        host.frame({own, 1'b1}, 8'h0A, 3, wd, rd);
        for (int k = 0; k < 3; k++) check(rd[k], m[10][7:0]);
        check({irq_oe, irq_out}, 8'h02);
        wd[0] = 8'h04;
        wr(5, 1);
        check({irq_oe, irq_out}, 8'h00);
        end_of_test();
    end
endmodule
